/* File: design/amp_sweep_pkg.sv */
// Shared constants and types for the amplitude sweep sequencer
package amp_sweep_pkg;
  // Amplitude values in 0.1 dB units, signed
  localparam int AMP_W       = 16;
  // Sweep time in whole milliseconds
  localparam int TIME_W      = 20;
  localparam int COUNT_W     = 20;
  // Timebase: 125 MHz reference
  localparam int CLK_HZ      = 125_000_000;
  localparam int MS_PER_S    = 1000;
  localparam int CYC_PER_MS  = CLK_HZ / MS_PER_S;
  // Least dwell per step and least step
  localparam int DWELL_MS    = 3;
  localparam int MIN_STEP    = 1;
  localparam int MIN_STEPS   = 5;
  localparam logic [TIME_W-1:0] TIME_RESET = 20'h003e8;
  typedef enum logic [1:0] {
    MODE_NONE   = 2'b00,
    MODE_AUTO   = 2'b01,
    MODE_MANUAL = 2'b10,
    MODE_SINGLE = 2'b11
  } mode_t;
endpackage

/* File: design/sweep_step_calc.sv */
// Step count and dwell per step from span and sweep time
`timescale 1ns/1ns
module sweep_step_calc #(
  parameter int AMP_W   = amp_sweep_pkg::AMP_W,
  parameter int TIME_W  = amp_sweep_pkg::TIME_W,
  parameter int COUNT_W = amp_sweep_pkg::COUNT_W
) (
  input  wire logic [AMP_W-1:0]   span,
  input  wire logic [TIME_W-1:0]  sweep_ms,
  output logic      [COUNT_W-1:0] step_count,
  output logic      [COUNT_W-1:0] step_dwell_ms
);
  logic [COUNT_W-1:0] time_steps;
  logic [COUNT_W-1:0] span_steps;
  logic [TIME_W-1:0]  thirds;

  // Time-limited count, floored at five
  always_comb begin
    thirds = sweep_ms / TIME_W'(amp_sweep_pkg::DWELL_MS);
    time_steps = COUNT_W'(thirds) - COUNT_W'(1);
    if (thirds < TIME_W'(amp_sweep_pkg::MIN_STEPS + 1)) begin
      time_steps = COUNT_W'(amp_sweep_pkg::MIN_STEPS);
    end
    span_steps = COUNT_W'(span) / COUNT_W'(amp_sweep_pkg::MIN_STEP);
    step_count = (span_steps < time_steps) ? span_steps : time_steps;
    if (step_count == '0) begin
      step_count = COUNT_W'(1);
    end
    // Evenly divide the time over the points, never below the least dwell
    step_dwell_ms = COUNT_W'(sweep_ms) / (step_count + COUNT_W'(1));
    if (step_dwell_ms < COUNT_W'(amp_sweep_pkg::DWELL_MS)) begin
      step_dwell_ms = COUNT_W'(amp_sweep_pkg::DWELL_MS);
    end
  end
endmodule

/* File: design/dwell_timer.sv */
// Dwell timer issuing one tick per step interval
`timescale 1ns/1ns
module dwell_timer #(
  parameter int COUNT_W = amp_sweep_pkg::COUNT_W
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_sync_n,
  input  wire logic               run,
  input  wire logic [COUNT_W-1:0] dwell_ms,
  output logic                    tick
);
  localparam int CYC_W = $clog2(amp_sweep_pkg::CYC_PER_MS);
  logic [CYC_W-1:0]   cyc;
  logic [COUNT_W-1:0] ms;
  logic               ms_tick;

  assign ms_tick = (cyc == CYC_W'(amp_sweep_pkg::CYC_PER_MS - 1));

  // Millisecond prescaler; restarts whenever the sweep is idle
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cyc <= '0;
    end else if (!run || ms_tick) begin
      cyc <= '0;
    end else begin
      cyc <= cyc + CYC_W'(1);
    end
  end

  // Millisecond count up to the dwell
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ms   <= '0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (!run) begin
        ms <= '0;
      end else if (ms_tick) begin
        if (ms + COUNT_W'(1) >= dwell_ms) begin
          ms   <= '0;
          tick <= 1'b1;
        end else begin
          ms <= ms + COUNT_W'(1);
        end
      end
    end
  end
endmodule

/* File: design/amplitude_sweep_sequencer.sv */
// Amplitude sweep sequencer: auto, manual and single sweep control
// What this block does
// R1: Mode selection needs an enabled end-point
// R2: Auto sweeps start to stop, repeating forever
// R3: Manual during sweep halts, shows output
// R4: Manual waits; each step command moves one
// R5: Remote up/down commands act as steps
// R6: Single starts or restarts one pass, holds
// R7: Single indicator only during the pass
// R8: Double on/off toggle restarts single pass
// R9: Missing sweep time keeps last value
// R10: Step never below 0.1 dB
// R11: Dwell per step at least 3 ms
// R12: Step count is min of span, time limit
// R13: Step size max of 0.1 dB, span/count
// R14: End-points held in 0.1 dB integers
// R15: Time-limited step count at least five
// R16: Derivation for log sweep; linear by fixed step
// R17: Disabling end-points stops, output at remaining
// R18: Time divided evenly over pass points
// R19: Indicator low unless a sweep runs or a manual step was taken
`timescale 1ns/1ns
module amplitude_sweep_sequencer #(
  parameter int AMP_W   = amp_sweep_pkg::AMP_W,
  parameter int TIME_W  = amp_sweep_pkg::TIME_W,
  parameter int COUNT_W = amp_sweep_pkg::COUNT_W
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              auto_sweep_cmd,
  input  wire logic              manual_sweep_cmd,
  input  wire logic              single_sweep_cmd,
  input  wire logic              step_up_cmd,
  input  wire logic              step_down_cmd,
  input  wire logic              start_level_cmd,
  input  wire logic [AMP_W-1:0]  start_level,
  input  wire logic              stop_level_cmd,
  input  wire logic [AMP_W-1:0]  stop_level,
  input  wire logic              start_on_cmd,
  input  wire logic              start_off_cmd,
  input  wire logic              stop_on_cmd,
  input  wire logic              stop_off_cmd,
  input  wire logic              start_active_fn,
  input  wire logic              stop_active_fn,
  input  wire logic              sweep_time_cmd,
  input  wire logic [TIME_W-1:0] sweep_time,
  input  wire logic              linear_mode,
  input  wire logic [AMP_W-1:0]  linear_step,
  output logic      [AMP_W-1:0]  output_level,
  output logic                   output_enable,
  output logic                   sweep_active_indicator,
  output logic      [1:0]        sweep_mode,
  output logic                   mode_rejected,
  output logic      [TIME_W-1:0] sweep_time_value,
  output logic      [COUNT_W-1:0] step_count_value
);
  logic                rst_meta_n;
  logic                rst_sync_n;
  logic signed [AMP_W-1:0] start_q;
  logic signed [AMP_W-1:0] stop_q;
  logic                start_en;
  logic                stop_en;
  amp_sweep_pkg::mode_t mode;
  logic                running;
  logic                manual_stepped;
  logic [COUNT_W-1:0]  step_idx;
  logic [TIME_W-1:0]   time_ms;
  logic [AMP_W-1:0]    span;
  logic [COUNT_W-1:0]  step_count;
  logic [COUNT_W-1:0]  dwell_ms;
  logic                tick;
  logic                any_en;
  logic                both_en;
  logic                mode_req;
  logic                toggle_pending;
  logic                restart_toggle;
  logic                endpoint_toggle;
  logic signed [AMP_W-1:0] next_level;

  // Point n of the pass, truncated to 0.1 dB
  // Division rounds toward the start end-point, so a pass never
  // overshoots the stop value; the clamp below catches index overrun.
  // Linear mode takes a fixed increment in place of the span/total division.
  function automatic logic signed [AMP_W-1:0] point_at(
    input logic signed [AMP_W-1:0] a,
    input logic signed [AMP_W-1:0] b,
    input logic [COUNT_W-1:0]      n,
    input logic [COUNT_W-1:0]      total,
    input logic                    lin,
    input logic [AMP_W-1:0]        lstep
  );
    logic signed [AMP_W+COUNT_W:0] delta;
    delta = '0;
    if (lin) begin
      delta = $signed({1'b0, (AMP_W+COUNT_W)'(lstep) * (AMP_W+COUNT_W)'(n)});  // [R16]
    end else begin
      delta = $signed({1'b0, (AMP_W+COUNT_W)'(amp_abs(b - a)) * (AMP_W+COUNT_W)'(n)}) /
              $signed({1'b0, (AMP_W+COUNT_W)'(total)});  // [R13] [R10]
    end
    if (delta > $signed({1'b0, (AMP_W+COUNT_W)'(amp_abs(b - a))})) begin
      delta = $signed({1'b0, (AMP_W+COUNT_W)'(amp_abs(b - a))});
    end
    return (b >= a) ? AMP_W'(a + AMP_W'(delta)) : AMP_W'(a - AMP_W'(delta));
  endfunction

  function automatic logic [AMP_W-1:0] amp_abs(input logic signed [AMP_W-1:0] v);
    return (v < 0) ? AMP_W'(-v) : AMP_W'(v);
  endfunction

  // Reset released through two flops
  // Only the synchronised copy resets the logic, so release never
  // lands close to an edge for some flops and not for others.
  // Assertion stays asynchronous: the block goes quiet at once.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Enable and command decode shared by the mode and pass logic
  assign any_en   = start_en || stop_en;
  assign both_en  = start_en && stop_en;
  assign mode_req = auto_sweep_cmd || manual_sweep_cmd || single_sweep_cmd;
  assign span     = amp_abs(stop_q - start_q);  // [R14]
  assign endpoint_toggle = (start_active_fn && (start_on_cmd || start_off_cmd)) ||
                           (stop_active_fn && (stop_on_cmd || stop_off_cmd));
  assign restart_toggle  = endpoint_toggle && toggle_pending && (mode == amp_sweep_pkg::MODE_SINGLE);

  // Step arithmetic is combinational; its inputs only change on rare
  // commands, so the long divide path has many cycles to settle
  sweep_step_calc #(
    .AMP_W   (AMP_W),
    .TIME_W  (TIME_W),
    .COUNT_W (COUNT_W)
  ) u_calc (
    .span          (span),
    .sweep_ms      (time_ms),
    .step_count    (step_count),      // [R12] [R15]
    .step_dwell_ms (dwell_ms)         // [R18] [R11]
  );

  // Dwell ticks only while a timed pass runs
  dwell_timer #(
    .COUNT_W (COUNT_W)
  ) u_timer (
    .ref_clk    (ref_clk),
    .rst_sync_n (rst_sync_n),
    .run        (running),
    .dwell_ms   (dwell_ms),
    .tick       (tick)
  );

  // End-point values in 0.1 dB units and their enables
  // A level load also switches its end-point on; on/off keeps the value
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      start_q  <= '0;
      stop_q   <= '0;
      start_en <= 1'b0;
      stop_en  <= 1'b0;
    end else begin
      if (start_level_cmd) begin
        start_q  <= start_level;
        start_en <= 1'b1;
      end else if (start_on_cmd) begin
        start_en <= 1'b1;
      end else if (start_off_cmd) begin
        start_en <= 1'b0;
      end
      if (stop_level_cmd) begin
        stop_q  <= stop_level;
        stop_en <= 1'b1;
      end else if (stop_on_cmd) begin
        stop_en <= 1'b1;
      end else if (stop_off_cmd) begin
        stop_en <= 1'b0;
      end
    end
  end

  // Sweep time is held until a new one is given
  // A zero time is taken as a query and leaves the value alone
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      time_ms <= amp_sweep_pkg::TIME_RESET;
    end else if (sweep_time_cmd && sweep_time != '0) begin
      time_ms <= sweep_time;  // [R9]
    end
  end

  // Second toggle of a pair restarts; pending flag tracks the first
  // A mode command forgets a half-finished pair unless a toggle comes in the same cycle
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      toggle_pending <= 1'b0;
    end else if (endpoint_toggle) begin
      toggle_pending <= !toggle_pending;
    end else if (mode_req) begin
      toggle_pending <= 1'b0;
    end
  end

  // Mode selection, refused with no end-point on
  // Priority on coincident commands: single, then manual, then auto
  // Mode falls back to none only once both end-points are off
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode          <= amp_sweep_pkg::MODE_NONE;
      mode_rejected <= 1'b0;
    end else begin
      mode_rejected <= mode_req && !any_en;  // [R1]
      if (mode_req && any_en) begin
        if (single_sweep_cmd) begin
          mode <= amp_sweep_pkg::MODE_SINGLE;
        end else if (manual_sweep_cmd) begin
          mode <= amp_sweep_pkg::MODE_MANUAL;
        end else begin
          mode <= amp_sweep_pkg::MODE_AUTO;
        end
      end else if (!any_en) begin
        mode <= amp_sweep_pkg::MODE_NONE;  // [R17]
      end
    end
  end

  // Pass progress and run state
  // Manual keeps step_idx, so the halt point is where stepping resumes.
  // A restart pair ends with an end-point coming back on while its
  // enable is still low at that edge, so the restart takes precedence.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      running        <= 1'b0;
      manual_stepped <= 1'b0;
      step_idx       <= '0;
    end else if (!both_en && !restart_toggle) begin
      running        <= 1'b0;  // [R17]
      manual_stepped <= 1'b0;
    end else if (mode_req && any_en) begin
      manual_stepped <= 1'b0;
      if (manual_sweep_cmd && !single_sweep_cmd) begin
        running <= 1'b0;  // [R3] [R4]
      end else begin
        running  <= 1'b1;  // [R2] [R6]
        step_idx <= '0;
      end
    end else if (restart_toggle) begin
      running  <= 1'b1;  // [R8]
      step_idx <= '0;
    end else if (mode == amp_sweep_pkg::MODE_MANUAL) begin
      if (step_up_cmd && step_idx < step_count) begin
        step_idx       <= step_idx + COUNT_W'(1);  // [R4] [R5]
        manual_stepped <= 1'b1;
      end else if (step_down_cmd && step_idx != '0) begin
        step_idx       <= step_idx - COUNT_W'(1);  // [R5]
        manual_stepped <= 1'b1;
      end
    end else if (running && tick) begin
      if (step_idx >= step_count) begin
        if (mode == amp_sweep_pkg::MODE_AUTO) begin
          step_idx <= '0;  // [R2]
        end else begin
          running <= 1'b0;  // [R6] [R7]
        end
      end else begin
        step_idx <= step_idx + COUNT_W'(1);  // [R18]
      end
    end
  end

  // Output level: a point of the pass, or the lone end-point left on
  // With one end-point left the span means nothing, so no point is used
  always_comb begin
    next_level = point_at(start_q, stop_q, step_idx, step_count, linear_mode, linear_step);
    if (!both_en) begin
      next_level = start_en ? start_q : stop_q;  // [R17]
    end
  end

  // Registered data outputs
  // Everything seen outside is a flop, one edge behind the state
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      output_level           <= '0;
      output_enable          <= 1'b0;
      sweep_active_indicator <= 1'b0;
      sweep_mode             <= 2'b00;
      sweep_time_value       <= '0;
      step_count_value       <= '0;
    end else begin
      output_level           <= next_level;  // [R3]
      output_enable          <= any_en;
      sweep_active_indicator <= both_en && (running ||
                                (mode == amp_sweep_pkg::MODE_MANUAL && manual_stepped));  // [R7] [R19]
      sweep_mode             <= mode;
      sweep_time_value       <= time_ms;  // [R9]
      step_count_value       <= step_count;
    end
  end
endmodule

/* File: test/sweep_checker_asserts.sv */
// Port-level checks for the amplitude sweep sequencer
`timescale 1ns/1ns
module sweep_checker #(
  parameter int AMP_W  = 16,
  parameter int TIME_W = 20
) (
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic              auto_sweep_cmd,
  input wire logic              manual_sweep_cmd,
  input wire logic              single_sweep_cmd,
  input wire logic              step_up_cmd,
  input wire logic              step_down_cmd,
  input wire logic              start_level_cmd,
  input wire logic              stop_level_cmd,
  input wire logic              sweep_time_cmd,
  input wire logic [TIME_W-1:0] sweep_time,
  input wire logic [AMP_W-1:0]  output_level,
  input wire logic              output_enable,
  input wire logic              sweep_active_indicator,
  input wire logic [1:0]        sweep_mode,
  input wire logic              mode_rejected,
  input wire logic [TIME_W-1:0] sweep_time_value
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic              mode_cmd;
  logic              lvl_cmd;
  logic              any_cmd;
  logic [TIME_W-1:0] last_time;
  // Command groups; output_enable lags end-point loads by two edges
  assign mode_cmd = auto_sweep_cmd | manual_sweep_cmd | single_sweep_cmd;
  assign lvl_cmd  = start_level_cmd | stop_level_cmd;
  assign any_cmd  = mode_cmd | lvl_cmd | step_up_cmd | step_down_cmd;
  // Last accepted sweep time, zero is not a value
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_time <= '0;
    end else if (sweep_time_cmd && sweep_time != '0) begin
      last_time <= sweep_time;
    end
  end
  sequence s_reject;
    ##[1:2] mode_rejected;
  endsequence
  reject_no_end_a: assert property (mode_cmd && !output_enable && !lvl_cmd && !$past(lvl_cmd)
    && !$past(lvl_cmd, 2) |-> s_reject) else $error("mode select not refused");
  reject_keeps_mode_a: assert property (mode_rejected |-> $stable(sweep_mode))
    else $error("refused select changed mode");
  auto_select_a: assert property (auto_sweep_cmd && !manual_sweep_cmd && !single_sweep_cmd
    && output_enable |-> ##[1:2] sweep_mode == amp_sweep_pkg::MODE_AUTO) else $error("auto not taken");
  manual_select_a: assert property (manual_sweep_cmd && !single_sweep_cmd && output_enable
    |-> ##[1:2] sweep_mode == amp_sweep_pkg::MODE_MANUAL) else $error("manual not taken");
  manual_holds_a: assert property (sweep_mode == amp_sweep_pkg::MODE_MANUAL && !any_cmd
    && !$past(any_cmd) && !$past(any_cmd, 2) |-> $stable(output_level)) else $error("manual moved");
  idle_low_a: assert property (sweep_mode == amp_sweep_pkg::MODE_NONE
    && $past(sweep_mode) == amp_sweep_pkg::MODE_NONE |-> !sweep_active_indicator) else $error("idle active");
  both_off_none_a: assert property (!output_enable && !$past(output_enable)
    |-> sweep_mode == amp_sweep_pkg::MODE_NONE) else $error("mode without end-point");
  time_load_a: assert property (sweep_time_cmd && sweep_time != '0
    |-> ##[1:2] sweep_time_value == last_time) else $error("sweep time not loaded");
endmodule
bind amplitude_sweep_sequencer sweep_checker #(.AMP_W(AMP_W), .TIME_W(TIME_W)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .auto_sweep_cmd(auto_sweep_cmd), .manual_sweep_cmd(manual_sweep_cmd),
  .single_sweep_cmd(single_sweep_cmd), .step_up_cmd(step_up_cmd), .step_down_cmd(step_down_cmd),
  .start_level_cmd(start_level_cmd), .stop_level_cmd(stop_level_cmd), .sweep_time_cmd(sweep_time_cmd),
  .sweep_time(sweep_time), .output_level(output_level), .output_enable(output_enable),
  .sweep_active_indicator(sweep_active_indicator), .sweep_mode(sweep_mode),
  .mode_rejected(mode_rejected), .sweep_time_value(sweep_time_value));

/* File: test/panel_model.sv */
// Front panel and remote controller issuing command pulses
`timescale 1ns/1ns
module panel_model (
  input  wire logic ref_clk,
  output logic [11:0] keys,
  output logic [15:0] level,
  output logic [19:0] time_ms
);
  initial begin
    keys    = 12'h000;
    level   = 16'h0000;
    time_ms = 20'h00000;
  end
  // One pulse per call, launched on the falling edge; up/down act as single steps
  // Data lines flip after the pulse so stale values are never read
  task automatic press(input int k, input logic [15:0] a, input logic [19:0] t);
    @(negedge ref_clk);
    keys[k] = 1'b1;
    level   = a;
    time_ms = t;
    @(negedge ref_clk);
    keys    = 12'h000;
    level   = ~a;
    time_ms = ~t;
  endtask
endmodule

/* File: test/amplitude_sweep_sequencer_bench.sv */
// Self-checking bench for the amplitude sweep sequencer
`timescale 1ns/1ns
module amplitude_sweep_sequencer_bench;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] keys;
  logic [15:0] level;
  logic [19:0] time_ms;
  logic [15:0] output_level;
  logic        output_enable;
  logic        active;
  logic [1:0]  sweep_mode;
  logic [19:0] time_value;
  logic [19:0] count_value;
  logic        rejected;
  logic        start_fn = 1'b0;
  int          errors = 0;
  int          total_checks = 0;
  always #4 ref_clk = ~ref_clk;
  panel_model panel (.ref_clk(ref_clk), .keys(keys), .level(level), .time_ms(time_ms));
  // Linear inputs held off: log sweep only; start active function driven
  amplitude_sweep_sequencer DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .auto_sweep_cmd(keys[0]), .manual_sweep_cmd(keys[1]),
    .single_sweep_cmd(keys[2]), .step_up_cmd(keys[3]), .step_down_cmd(keys[4]),
    .start_level_cmd(keys[5]), .start_level(level), .stop_level_cmd(keys[6]), .stop_level(level),
    .start_on_cmd(keys[7]), .start_off_cmd(keys[8]), .stop_on_cmd(keys[9]), .stop_off_cmd(keys[10]),
    .start_active_fn(start_fn), .stop_active_fn(1'b0), .sweep_time_cmd(keys[11]), .sweep_time(time_ms),
    .linear_mode(1'b0), .linear_step(16'h0000), .output_level(output_level),
    .output_enable(output_enable), .sweep_active_indicator(active), .sweep_mode(sweep_mode),
    .mode_rejected(rejected), .sweep_time_value(time_value), .step_count_value(count_value));
  task automatic chk_level(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t level %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t value %h want %h", $time, got, exp);
    end
  endtask
  // Press then let the registered outputs land
  task automatic act(input int k, input logic [15:0] a, input logic [19:0] t);
    panel.press(k, a, t);
    repeat (3) @(negedge ref_clk);
  endtask
  // Refusal pulse stands one cycle, so look right after the press
  task automatic t_reject;
    panel.press(0, 16'h0000, 20'h00000);
    chk_word({19'h0, rejected}, 20'h00001);
    repeat (3) @(negedge ref_clk);
    chk_word({19'h0, rejected}, 20'h00000);
    chk_word({18'h0, sweep_mode}, 20'h00000);
    chk_word(time_value, 20'h003e8);
    $display("test reject done");
  endtask
  task automatic t_time;
    act(11, 16'h0000, 20'h00000);
    chk_word(time_value, 20'h003e8);
    act(11, 16'h0000, 20'h00021);
    chk_word(time_value, 20'h00021);
    $display("test time done");
  endtask
  // Span 50 tenths, 33 ms: ten steps of five tenths
  task automatic t_single_manual;
    act(5, 16'hff9c, 20'h00000);
    act(6, 16'hffce, 20'h00000);
    chk_word(count_value, 20'h0000a);
    act(2, 16'h0000, 20'h00000);
    chk_word({18'h0, sweep_mode}, 20'h00003);
    chk_word({19'h0, active}, 20'h00001);
    chk_level(output_level, 16'hff9c);
    act(1, 16'h0000, 20'h00000);
    chk_word({18'h0, sweep_mode}, 20'h00002);
    chk_level(output_level, 16'hff9c);
    act(3, 16'h0000, 20'h00000);
    chk_level(output_level, 16'hffa1);
    chk_word({19'h0, active}, 20'h00001);
    act(4, 16'h0000, 20'h00000);
    act(4, 16'h0000, 20'h00000);
    chk_level(output_level, 16'hff9c);
    act(11, 16'h0000, 20'h00014);
    chk_word(count_value, 20'h00005);
    $display("test single and manual done");
  endtask
  // Off then on with start as active function restarts the single pass
  task automatic t_restart;
    act(2, 16'h0000, 20'h00000);
    chk_word({19'h0, active}, 20'h00001);
    start_fn = 1'b1;
    act(8, 16'h0000, 20'h00000);
    chk_word({19'h0, active}, 20'h00000);
    chk_word({18'h0, sweep_mode}, 20'h00003);
    act(7, 16'h0000, 20'h00000);
    chk_word({19'h0, active}, 20'h00001);
    chk_level(output_level, 16'hff9c);
    start_fn = 1'b0;
    $display("test restart done");
  endtask
  task automatic t_auto_stop;
    act(0, 16'h0000, 20'h00000);
    chk_word({18'h0, sweep_mode}, 20'h00001);
    chk_word({19'h0, active}, 20'h00001);
    act(8, 16'h0000, 20'h00000);
    chk_level(output_level, 16'hffce);
    chk_word({19'h0, active}, 20'h00000);
    act(10, 16'h0000, 20'h00000);
    chk_word({18'h0, sweep_mode}, 20'h00000);
    chk_word({19'h0, output_enable}, 20'h00000);
    $display("test auto and stop done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Hang guard well past the 90 or so cycles the tests need
  initial begin
    #100000;
    errors++;
    final_report();
  end
  initial begin
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_reject();
    t_time();
    t_single_manual();
    t_restart();
    t_auto_stop();
    final_report();
  end
endmodule
